// [shared/spbcg_consts.svh]
// Functional notes
// - Four modes: normal, double, master, slave
// - Sync select zero async, one sync
// - Sync: direction output master, input slave
// - Transfer clock pin only used in sync
// - Down-counter reloads at zero or low write
// - One baud tick per zero, fosc/(div+1)
// - Transmitter divides ticks by 16, 8, 2
// - Receiver recovery uses 16, 8, 2 states
// - Bit rate per mode from divisor
// - Divisor is high:low, range 0-4095
// - Double speed only affects async operation
// - Double speed: receiver uses 8 samples
// - Slave clock synchronised then edge-detected
// - Master drives clock pin, slave reads it
// - Sample receive opposite to transmit change
// - Polarity zero: change rising, sample falling
// - One write buffer ahead of shifter, gapless
// - Two-level receive buffer, frame/overrun/parity errors
// - Separate tx complete, tx empty, rx complete
`ifndef SPBCG_CONSTS_SVH
`define SPBCG_CONSTS_SVH
`define SPBCG_DIV_W 12
`define SPBCG_LOW_W 8
`define SPBCG_DATA_W 8
`define SPBCG_NORM_LAST 4'hF
`define SPBCG_NORM_MID 4'h7
`define SPBCG_DBL_LAST 4'h7
`define SPBCG_DBL_MID 4'h3
`define SPBCG_SYNC_LAST 4'h1
`define SPBCG_SYNC_MID 4'h0
`define SPBCG_BIT_LAST 3'h7
`define SPBCG_SYNC_STAGES 2
`define SPBCG_RXBUF_DEPTH 2
`endif

// [shared/spbcg_pkg.sv]
`include "spbcg_consts.svh"
package spbcg_pkg;
	typedef enum logic [1:0] {
		MODE_ASYNC_NORM, MODE_ASYNC_DBL, MODE_SYNC_MASTER, MODE_SYNC_SLAVE
	} spbcg_mode_t;
	typedef enum logic [2:0] {TX_IDLE, TX_START, TX_DATA, TX_PARITY, TX_STOP} spbcg_tx_state_t;
	typedef enum logic [2:0] {RX_IDLE, RX_START, RX_DATA, RX_PARITY, RX_STOP} spbcg_rx_state_t;
	typedef struct packed {
		logic sync_mode_select;
		logic double_speed_bit;
		logic transfer_clock_direction;
		logic clock_polarity_select;
		logic parity_enable;
		logic parity_odd;
	} spbcg_cfg_t;
	typedef struct packed {
		logic overrun;
		logic parity_err;
		logic frame_err;
		logic [`SPBCG_DATA_W-1:0] data;
	} spbcg_rx_word_t;
	typedef struct packed {
		logic tx_complete;
		logic tx_buffer_empty;
		logic rx_complete;
	} spbcg_evt_t;
endpackage

// [sim/spbcg_peer.sv]
`timescale 1ns/10ps
module spbcg_peer (
	input wire logic clk_sys,
	input wire logic transmit_line,
	output logic receive_line,
	output logic xck_in,
	output logic got,
	output logic [7:0] got_byte
);
	int rx_bit = 16;
	initial begin
		receive_line = 1'b1;
		xck_in = 1'b0;
		got = 1'b0;
		got_byte = 8'h00;
	end
	// Async frame with parity; line idles high like a pulled-up wire
	task automatic send_async(input logic [7:0] d, input int bitc, input logic par,
		input logic stop);
		logic [10:0] f;
		f = {stop, par, d, 1'b0};
		for (int i = 0; i < 11; i++) begin
			receive_line = f[i];
			repeat (bitc) @(negedge clk_sys);
		end
		receive_line = 1'b1;
	endtask
	// Clock rests at idle level between frames; 8-cycle period stays under fosc/4
	task automatic send_sync(input logic [7:0] d, input logic pol);
		logic [9:0] f;
		f = {1'b1, d, 1'b0};
		xck_in = pol;
		repeat (8) @(negedge clk_sys);
		for (int i = 0; i < 10; i++) begin
			xck_in = ~pol;
			receive_line = f[i];
			repeat (4) @(negedge clk_sys);
			xck_in = pol;
			repeat (4) @(negedge clk_sys);
		end
		receive_line = 1'b1;
	endtask
	// Mid-bit sampling; a low stop bit gives no pulse, so the word stays owed
	always begin
		@(negedge transmit_line);
		repeat (rx_bit / 2) @(posedge clk_sys);
		for (int i = 0; i < 8; i++) begin
			repeat (rx_bit) @(posedge clk_sys);
			got_byte[i] = transmit_line;
		end
		repeat (rx_bit) @(posedge clk_sys);
		@(negedge clk_sys);
		got = transmit_line;
		@(negedge clk_sys);
		got = 1'b0;
	end
endmodule // spbcg_peer

// [sim/tb_top.sv]
`timescale 1ns/10ps
module tb_top import spbcg_pkg::*; ();
	logic clk_sys = 1'b0;
	logic rstn = 1'b0;
	spbcg_cfg_t cfg = '0;
	logic power_gate = 1'b0;
	logic [7:0] baud_divisor_low = 8'h00;
	logic [3:0] baud_divisor_high = 4'h0;
	logic baud_low_write = 1'b0;
	logic tx_valid = 1'b0;
	logic rx_ready = 1'b1;
	logic [7:0] tx_data = 8'h00;
	logic tx_ready, rx_valid, transmit_line, receive_line, xck_in, xck_out, xck_oe, got;
	logic [7:0] got_byte;
	spbcg_rx_word_t rx_word;
	spbcg_evt_t events;
	spbcg_mode_t mode;
	int error_cnt = 0;
	int cmp_count = 0;
	int cyc = 0;
	int txc = 0;
	int rxc = 0;
	int bitc = 16;
	int div = 0;
	logic [7:0] tx_q[$];
	spbcg_rx_word_t rx_q[$];

	always #50 clk_sys = ~clk_sys;

	spbcg_top u_dut (.clk_sys(clk_sys), .rstn(rstn), .cfg(cfg), .power_gate(power_gate),
		.baud_divisor_low(baud_divisor_low), .baud_divisor_high(baud_divisor_high),
		.baud_low_write(baud_low_write), .tx_valid(tx_valid), .tx_ready(tx_ready),
		.tx_data(tx_data), .rx_valid(rx_valid), .rx_ready(rx_ready), .rx_word(rx_word),
		.events(events), .mode(mode), .receive_line(receive_line),
		.transmit_line(transmit_line), .xck_in(xck_in), .xck_out(xck_out), .xck_oe(xck_oe));
	spbcg_peer u_peer (.clk_sys(clk_sys), .transmit_line(transmit_line),
		.receive_line(receive_line), .xck_in(xck_in), .got(got), .got_byte(got_byte));

	task automatic check(input logic [15:0] seen, input logic [15:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			error_cnt++;
			$display("CHECK FAILED t=%0t seen %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic give_verdict();
		$display("errors %0d comparisons %0d", error_cnt, cmp_count);
		if (error_cnt == 0 && cmp_count > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask

	// Oldest note against each result the moment it appears
	always @(posedge clk_sys) begin
		cyc <= cyc + 1;
		if (events.tx_complete === 1'b1) txc <= txc + 1;
		if (events.rx_complete === 1'b1) rxc <= rxc + 1;
		if (rx_valid === 1'b1 && rx_ready) begin
			if (rx_q.size() > 0) check(rx_word, rx_q.pop_front());
			else check(1'b1, 1'b0);
		end
		if (got === 1'b1) begin
			if (tx_q.size() > 0) check(got_byte, tx_q.pop_front());
			else check(1'b1, 1'b0);
		end
		if (cyc == 50000) begin
			error_cnt++;
			give_verdict();
		end
	end

	// Reload pulse with every divisor change, as software would write the low part
	task automatic set_cfg(input logic [5:0] c, input int d);
		spbcg_mode_t m;
		@(negedge clk_sys);
		cfg = c;
		{baud_divisor_high, baud_divisor_low} = 12'(d);
		baud_low_write = 1'b1;
		m = c[5] ? (c[3] ? MODE_SYNC_MASTER : MODE_SYNC_SLAVE)
			: (c[4] ? MODE_ASYNC_DBL : MODE_ASYNC_NORM);
		@(negedge clk_sys);
		baud_low_write = 1'b0;
		check(mode, m);
		check(xck_oe, c[5] & c[3]);
	endtask

	task automatic send_tx(input logic [7:0] d);
		tx_q.push_back(d);
		@(negedge clk_sys);
		tx_valid = 1'b1;
		tx_data = d;
		do @(posedge clk_sys); while (tx_ready !== 1'b1);
		@(negedge clk_sys);
		check({tx_ready, events.tx_buffer_empty}, 2'b00);
		tx_valid = 1'b0;
	endtask

	task automatic drain();
		repeat (4000) begin
			@(posedge clk_sys);
			if (tx_q.size() == 0 && rx_q.size() == 0) break;
		end
		repeat (2 * bitc) @(negedge clk_sys);
	endtask

	initial begin
		logic [7:0] d;
		int k;
		k = $urandom(24);
		repeat (2) @(negedge clk_sys);
		check({transmit_line, tx_ready, rx_valid, xck_out, events}, 7'b1100010);
		rstn = 1'b1;
		for (k = 0; k < 16; k++) set_cfg({k[3:0], 2'b00}, 0);
		// Two words back to back: one completion pulse only
		for (k = 0; k < 2; k++) begin
			div = $urandom % 3;
			bitc = (k[0] ? 8 : 16) * (div + 1);
			set_cfg({1'b0, k[0], 4'b0000}, div);
			u_peer.rx_bit = bitc;
			txc = 0;
			send_tx(8'($urandom));
			send_tx(8'($urandom));
			drain();
			check(txc, 1);
		end
		// Good frame, bad parity, low stop bit, at both async speeds
		for (k = 0; k < 6; k++) begin
			div = $urandom % 3;
			bitc = (k[0] ? 8 : 16) * (div + 1);
			// Odd parity on the two bad-parity frames
			set_cfg({1'b0, k[0], 2'b00, 1'b1, k[1]}, div);
			d = 8'($urandom);
			rx_q.push_back({1'b0, k / 2 == 1, k / 2 == 2, d});
			u_peer.send_async(d, bitc, ^d ^ k[1] ^ (k / 2 == 1), k / 2 != 2);
			drain();
		end
		// Third frame meets a full buffer; the next stored word carries overrun
		rx_ready = 1'b0;
		for (k = 0; k < 4; k++) begin
			d = 8'($urandom);
			if (k == 3) rx_ready = 1'b1;
			if (k != 2) rx_q.push_back({k == 3, 2'b00, d});
			u_peer.send_async(d, bitc, ^d, 1'b1);
			repeat (bitc) @(negedge clk_sys);
		end
		drain();
		div = $urandom % 3;
		set_cfg(6'b101000, div);
		do @(posedge clk_sys); while (xck_out !== 1'b1);
		do @(posedge clk_sys); while (xck_out !== 1'b0);
		k = 0;
		do begin
			@(posedge clk_sys);
			k++;
		end while (xck_out !== 1'b1);
		check(k, div + 1);
		@(negedge clk_sys);
		power_gate = 1'b1;
		repeat (2) @(negedge clk_sys);
		check({xck_out, tx_ready, transmit_line}, 3'b011);
		power_gate = 1'b0;
		for (k = 0; k < 2; k++) begin
			set_cfg({3'b100, k[0], 2'b00}, 0);
			d = 8'($urandom);
			rx_q.push_back({3'b000, d});
			u_peer.send_sync(d, k[0]);
			drain();
		end
		check(tx_q.size() + rx_q.size(), 0);
		check(rxc, 11);
		give_verdict();
	end
endmodule // tb_top

// [verilog/spbcg_buf2.sv]
`timescale 1ns/10ps
module spbcg_buf2 #(
	parameter int W = 8,
	parameter int DEPTH = 2
) (
	input wire logic clk_sys,
	input wire logic rstn,
	input wire logic in_valid,
	output logic in_ready,
	input wire logic [W-1:0] in_data,
	output logic out_valid,
	input wire logic out_ready,
	output logic [W-1:0] out_data
);
	localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
	localparam int CW = $clog2(DEPTH + 1);
	logic [W-1:0] mem [DEPTH];
	logic [PW-1:0] wr_ptr, rd_ptr;
	logic [CW-1:0] count;
	logic push, pop;
	assign in_ready = (count != CW'(DEPTH));
	assign out_valid = (count != '0);
	assign push = in_valid && in_ready;
	assign pop = out_valid && out_ready;
	assign out_data = mem[rd_ptr];
	always_ff @(posedge clk_sys) begin
		if (push) begin
			mem[wr_ptr] <= in_data;
		end
	end
	always_ff @(posedge clk_sys) begin
		if (!rstn) begin
			wr_ptr <= '0;
			rd_ptr <= '0;
			count <= '0;
		end else begin
			if (push) begin
				wr_ptr <= (wr_ptr == PW'(DEPTH - 1)) ? '0 : wr_ptr + 1'b1;
			end
			if (pop) begin
				rd_ptr <= (rd_ptr == PW'(DEPTH - 1)) ? '0 : rd_ptr + 1'b1;
			end
			count <= count + CW'(push) - CW'(pop);
		end
	end
endmodule // spbcg_buf2

// [verilog/spbcg_sync_edge.sv]
`timescale 1ns/10ps
module spbcg_sync_edge #(
	parameter int STAGES = 2,
	parameter logic RST_VAL = 1'b0
) (
	input wire logic clk_sys,
	input wire logic rstn,
	input wire logic async_in,
	output logic level,
	output logic rise,
	output logic fall
);
	logic [STAGES-1:0] chain;
	logic prev;
	// Only the last stage is looked at, never the first
	always_ff @(posedge clk_sys) begin
		if (!rstn) begin
			chain <= {STAGES{RST_VAL}};
			prev <= RST_VAL;
		end else begin
			chain <= {chain[STAGES-2:0], async_in};
			prev <= chain[STAGES-1];
		end
	end
	assign level = chain[STAGES-1];
	assign rise = chain[STAGES-1] && !prev;
	assign fall = !chain[STAGES-1] && prev;
endmodule // spbcg_sync_edge

// [verilog/spbcg_top.sv]
`timescale 1ns/10ps
`include "spbcg_consts.svh"
module spbcg_top import spbcg_pkg::*; #(
	parameter int DIV_W = `SPBCG_DIV_W
) (
	input wire logic clk_sys,
	input wire logic rstn,
	input wire spbcg_cfg_t cfg,
	input wire logic power_gate,
	input wire logic [`SPBCG_LOW_W-1:0] baud_divisor_low,
	input wire logic [DIV_W-`SPBCG_LOW_W-1:0] baud_divisor_high,
	input wire logic baud_low_write,
	input wire logic tx_valid,
	output logic tx_ready,
	input wire logic [`SPBCG_DATA_W-1:0] tx_data,
	output logic rx_valid,
	input wire logic rx_ready,
	output spbcg_rx_word_t rx_word,
	output spbcg_evt_t events,
	output spbcg_mode_t mode,
	input wire logic receive_line,
	output logic transmit_line,
	input wire logic xck_in,
	output logic xck_out,
	output logic xck_oe
);
	logic run;
	logic [DIV_W-1:0] divisor, baud_cnt;
	logic baud_tick;
	logic [3:0] bit_last, bit_mid;
	logic is_sync;
	logic xck_int;
	logic xck_lvl, xck_rise, xck_fall;
	logic sync_launch, sync_sample;
	logic rxd;
	logic [3:0] tx_div;
	logic tx_step, tx_take;
	logic [`SPBCG_DATA_W-1:0] tx_hold, tx_shift;
	logic tx_hold_valid;
	logic [2:0] tx_cnt;
	logic tx_par;
	logic tx_done;
	spbcg_tx_state_t tx_state;
	logic [3:0] rx_ph;
	logic rx_sample;
	logic [`SPBCG_DATA_W-1:0] rx_shift;
	logic [2:0] rx_cnt;
	logic rx_perr, rx_ferr, rx_push, rx_stored;
	logic ovr_pending;
	logic buf_in_ready;
	spbcg_rx_state_t rx_state;
	spbcg_rx_word_t buf_in;

	// Gated port behaves as held in reset, apart from the two input synchronisers, which reset on rstn only
	assign run = rstn && !power_gate;

	// Double speed ignored when sync is selected
	always_comb begin
		if (!cfg.sync_mode_select) begin
			mode = cfg.double_speed_bit ? MODE_ASYNC_DBL : MODE_ASYNC_NORM;
		end else begin
			mode = cfg.transfer_clock_direction ? MODE_SYNC_MASTER : MODE_SYNC_SLAVE;
		end
	end
	assign is_sync = cfg.sync_mode_select;

	// Samples per bit by mode
	always_comb begin
		case (mode)
			MODE_ASYNC_NORM: begin
				bit_last = `SPBCG_NORM_LAST;
				bit_mid = `SPBCG_NORM_MID;
			end
			MODE_ASYNC_DBL: begin
				bit_last = `SPBCG_DBL_LAST;
				bit_mid = `SPBCG_DBL_MID;
			end
			default: begin
				bit_last = `SPBCG_SYNC_LAST;
				bit_mid = `SPBCG_SYNC_MID;
			end
		endcase
	end

	// Baud generator
	assign divisor = {baud_divisor_high, baud_divisor_low};
	assign baud_tick = (baud_cnt == '0);
	always_ff @(posedge clk_sys) begin
		if (!run) begin
			baud_cnt <= '0;
		end else if (baud_low_write || baud_tick) begin
			baud_cnt <= divisor;
		end else begin
			baud_cnt <= baud_cnt - 1'b1;
		end
	end

	// Master clock: one toggle per tick gives divide by two
	always_ff @(posedge clk_sys) begin
		if (!run || mode != MODE_SYNC_MASTER) begin
			xck_int <= 1'b0;
		end else if (baud_tick) begin
			xck_int <= ~xck_int;
		end
	end
	assign xck_out = xck_int;
	assign xck_oe = (mode == MODE_SYNC_MASTER);

	// Slave clock: two stages then edge detect
	spbcg_sync_edge #(.STAGES(`SPBCG_SYNC_STAGES), .RST_VAL(1'b0)) u_xck_sync (
		.clk_sys(clk_sys),
		.rstn(rstn),
		.async_in(xck_in),
		.level(xck_lvl),
		.rise(xck_rise),
		.fall(xck_fall)
	);
	spbcg_sync_edge #(.STAGES(`SPBCG_SYNC_STAGES), .RST_VAL(1'b1)) u_rxd_sync (
		.clk_sys(clk_sys),
		.rstn(rstn),
		.async_in(receive_line),
		.level(rxd),
		.rise(),
		.fall()
	);

	// Launch and sample on opposite edges, chosen by polarity
	always_comb begin
		sync_launch = 1'b0;
		sync_sample = 1'b0;
		case (mode)
			MODE_SYNC_MASTER: begin
				sync_launch = baud_tick && (xck_int == cfg.clock_polarity_select);
				sync_sample = baud_tick && (xck_int != cfg.clock_polarity_select);
			end
			MODE_SYNC_SLAVE: begin
				sync_launch = cfg.clock_polarity_select ? xck_fall : xck_rise;
				sync_sample = cfg.clock_polarity_select ? xck_rise : xck_fall;
			end
			default: begin
				sync_launch = 1'b0;
				sync_sample = 1'b0;
			end
		endcase
	end

	// Transmit bit clock from baud ticks
	always_ff @(posedge clk_sys) begin
		if (!run || is_sync) begin
			tx_div <= 4'h0;
		end else if (baud_tick) begin
			tx_div <= (tx_div >= bit_last) ? 4'h0 : tx_div + 4'h1;
		end
	end
	assign tx_step = is_sync ? sync_launch : (baud_tick && tx_div == bit_last);

	// Write buffer ahead of the shifter
	assign tx_ready = !tx_hold_valid;
	assign tx_take = tx_step && tx_hold_valid && (tx_state == TX_IDLE || tx_state == TX_STOP);
	always_ff @(posedge clk_sys) begin
		if (!run) begin
			tx_hold_valid <= 1'b0;
			tx_hold <= '0;
		end else if (tx_valid && tx_ready) begin
			tx_hold_valid <= 1'b1;
			tx_hold <= tx_data;
		end else if (tx_take) begin
			tx_hold_valid <= 1'b0;
		end
	end

	// Transmitter; line register holds the bit now on the wire
	always_ff @(posedge clk_sys) begin
		if (!run) begin
			tx_state <= TX_IDLE;
			transmit_line <= 1'b1;
			tx_shift <= '0;
			tx_cnt <= 3'h0;
			tx_par <= 1'b0;
			tx_done <= 1'b0;
		end else begin
			tx_done <= 1'b0;
			case (tx_state)
				TX_IDLE: begin
					if (tx_take) begin
						transmit_line <= 1'b0;
						tx_shift <= tx_hold;
						tx_state <= TX_START;
					end
				end
				TX_START: begin
					if (tx_step) begin
						transmit_line <= tx_shift[0];
						tx_par <= (^tx_shift) ^ cfg.parity_odd;
						tx_cnt <= 3'h0;
						tx_state <= TX_DATA;
					end
				end
				TX_DATA: begin
					if (tx_step) begin
						tx_shift <= {1'b0, tx_shift[`SPBCG_DATA_W-1:1]};
						tx_cnt <= tx_cnt + 3'h1;
						if (tx_cnt != `SPBCG_BIT_LAST) begin
							transmit_line <= tx_shift[1];
						end else if (cfg.parity_enable) begin
							transmit_line <= tx_par;
							tx_state <= TX_PARITY;
						end else begin
							transmit_line <= 1'b1;
							tx_state <= TX_STOP;
						end
					end
				end
				TX_PARITY: begin
					if (tx_step) begin
						transmit_line <= 1'b1;
						tx_state <= TX_STOP;
					end
				end
				TX_STOP: begin
					if (tx_take) begin
						transmit_line <= 1'b0;
						tx_shift <= tx_hold;
						tx_state <= TX_START;
					end else if (tx_step) begin
						tx_state <= TX_IDLE;
						tx_done <= 1'b1;
					end
				end
				default: begin
					tx_state <= TX_IDLE;
					transmit_line <= 1'b1;
				end
			endcase
		end
	end

	// Receiver phase counter steps on raw baud ticks
	always_ff @(posedge clk_sys) begin
		if (!run || rx_state == RX_IDLE || is_sync) begin
			rx_ph <= 4'h0;
		end else if (baud_tick) begin
			if (rx_state == RX_START && rx_ph == bit_mid) begin
				rx_ph <= 4'h0;
			end else begin
				rx_ph <= (rx_ph >= bit_last) ? 4'h0 : rx_ph + 4'h1;
			end
		end
	end
	assign rx_sample = is_sync ? sync_sample : (baud_tick && rx_ph == bit_last);

	// Receiver; mid-bit sampling, false start rejected
	always_ff @(posedge clk_sys) begin
		if (!run) begin
			rx_state <= RX_IDLE;
			rx_shift <= '0;
			rx_cnt <= 3'h0;
			rx_perr <= 1'b0;
			rx_ferr <= 1'b0;
			rx_push <= 1'b0;
		end else begin
			rx_push <= 1'b0;
			case (rx_state)
				RX_IDLE: begin
					rx_cnt <= 3'h0;
					rx_perr <= 1'b0;
					if (is_sync ? (sync_sample && !rxd) : (baud_tick && !rxd)) begin
						rx_state <= is_sync ? RX_DATA : RX_START;
					end
				end
				RX_START: begin
					if (baud_tick && rx_ph == bit_mid) begin
						rx_state <= rxd ? RX_IDLE : RX_DATA;
					end
				end
				RX_DATA: begin
					if (rx_sample) begin
						rx_shift <= {rxd, rx_shift[`SPBCG_DATA_W-1:1]};
						rx_cnt <= rx_cnt + 3'h1;
						if (rx_cnt == `SPBCG_BIT_LAST) begin
							rx_state <= cfg.parity_enable ? RX_PARITY : RX_STOP;
						end
					end
				end
				RX_PARITY: begin
					if (rx_sample) begin
						rx_perr <= rxd != ((^rx_shift) ^ cfg.parity_odd);
						rx_state <= RX_STOP;
					end
				end
				RX_STOP: begin
					if (rx_sample) begin
						rx_ferr <= !rxd;
						rx_push <= 1'b1;
						rx_state <= RX_IDLE;
					end
				end
				default: begin
					rx_state <= RX_IDLE;
				end
			endcase
		end
	end

	// Overrun marks the next stored word; set wins over clear
	always_ff @(posedge clk_sys) begin
		if (!run) begin
			ovr_pending <= 1'b0;
			rx_stored <= 1'b0;
		end else begin
			rx_stored <= rx_push && buf_in_ready;
			if (rx_push && !buf_in_ready) begin
				ovr_pending <= 1'b1;
			end else if (rx_push) begin
				ovr_pending <= 1'b0;
			end
		end
	end
	always_comb begin
		buf_in.overrun = ovr_pending;
		buf_in.parity_err = rx_perr;
		buf_in.frame_err = rx_ferr;
		buf_in.data = rx_shift;
	end

	// Two-level receive buffer; a stalled reader fills it
	spbcg_buf2 #(.W($bits(spbcg_rx_word_t)), .DEPTH(`SPBCG_RXBUF_DEPTH)) u_rx_buf (
		.clk_sys(clk_sys),
		.rstn(run),
		.in_valid(rx_push),
		.in_ready(buf_in_ready),
		.in_data(buf_in),
		.out_valid(rx_valid),
		.out_ready(rx_ready),
		.out_data(rx_word)
	);

	always_comb begin
		events.tx_complete = tx_done;
		events.tx_buffer_empty = !tx_hold_valid;
		events.rx_complete = rx_stored;
	end

	default clocking @(posedge clk_sys); endclocking
	default disable iff (!run);

	baud_reload_a: assert property ((baud_tick || baud_low_write) |=> baud_cnt == $past(divisor))
		else $error("baud counter did not reload");
	baud_count_a: assert property ((!baud_tick && !baud_low_write) |=> baud_cnt == $past(baud_cnt) - 1'b1)
		else $error("baud counter did not count down");
	pin_dir_a: assert property (xck_oe |-> is_sync && cfg.transfer_clock_direction)
		else $error("clock pin driven outside master mode");
	master_toggle_a: assert property ((mode == MODE_SYNC_MASTER && baud_tick) ##1 (mode == MODE_SYNC_MASTER) |-> xck_out != $past(xck_out))
		else $error("master clock missed a toggle");
	slave_edge_a: assert property (xck_rise |-> xck_lvl && !$past(xck_lvl))
		else $error("slave edge without level change");
	opposite_edge_a: assert property (is_sync |-> !(sync_launch && sync_sample))
		else $error("launch and sample on same edge");
	dbl_sync_a: assert property (is_sync |-> mode != MODE_ASYNC_DBL)
		else $error("double speed took effect in sync mode");
	tx_divide_a: assert property ((!is_sync && tx_step) |-> baud_tick && tx_div == bit_last)
		else $error("transmit step off the divided tick");
	tx_gapless_a: assert property ((tx_state == TX_STOP && tx_step && tx_hold_valid) |=> tx_state == TX_START && !transmit_line)
		else $error("gap between buffered frames");
	rx_overrun_a: assert property ((rx_push && !buf_in_ready) |=> ovr_pending && !rx_stored)
		else $error("overrun not recorded");
	tx_done_a: assert property (events.tx_complete |-> $past(tx_state) == TX_STOP && tx_state == TX_IDLE)
		else $error("transmit complete out of place");

	norm_rx_c: cover property (mode == MODE_ASYNC_NORM && rx_stored);
	dbl_rx_c: cover property (mode == MODE_ASYNC_DBL && rx_stored);
	master_tx_c: cover property (mode == MODE_SYNC_MASTER && events.tx_complete);
	slave_rx_c: cover property (mode == MODE_SYNC_SLAVE && rx_stored);
	overrun_c: cover property (rx_push && !buf_in_ready);
endmodule // spbcg_top
